// ==== design/sssp_params.svh ====
/*
 * constants of the spi slave shift port: widths, counts, reset values.
 * assumes inclusion by bare name from the package and the design files.
 */
`ifndef SSSP_PARAMS_SVH
`define SSSP_PARAMS_SVH

`define SSSP_BYTE_W      8
`define SSSP_CNT_W       3
`define SSSP_LAST_BIT    3'h7
`define SSSP_CNT_RST     3'h0
`define SSSP_BYTE_RST    8'h00
`define SSSP_SYNC_W      3
`define SSSP_RST_STAGES  2

`endif

// ==== design/sssp_pkg.sv ====
/*
 * types of the spi slave shift port: configuration and flag carriers,
 * byte type and controller states.
 * assumes sssp_params.svh on the include path.
 */
`include "sssp_params.svh"

package sssp_pkg;

   typedef logic [`SSSP_BYTE_W-1:0] sssp_byte_t;
   typedef logic [`SSSP_CNT_W-1:0]  sssp_cnt_t;

   // static setup, changed by software only while the port is off
   typedef struct packed {
      logic port_enable_bit;
      logic ss_control_enable;
      logic clock_idle_polarity;
      logic clock_edge_select;
      logic buffer_overwrite_enable;
   } sssp_cfg_s;

   typedef struct packed {
      logic transfer_done_flag;
      logic buffer_full;
      logic overflow;
      logic write_collision;
   } sssp_flags_s;

   typedef enum logic [1:0] {
      SSSP_OFF,
      SSSP_IDLE,
      SSSP_XFER
   } sssp_state_e;

endpackage

// ==== design/sssp_sync.sv ====
/*
 * two-flop synchroniser, one chain per bit.
 * assumes inputs asynchronous to clock; outputs only from the second flop.
 */
`timescale 1ns/1ps
`default_nettype none

module sssp_sync #(
   parameter int W = 1
) (
   input  wire logic          clock,
   input  wire logic          rst_n,
   input  wire logic [W-1:0]  async_in,
   input  wire logic [W-1:0]  rst_val,
   output logic      [W-1:0]  sync_out
);

   logic [W-1:0] meta_r;

   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         // reset value is always 0; the rst_val tie-off at the instance is unused
         always_ff @(posedge clock or negedge rst_n)
         begin
            if (!rst_n)
            begin
               meta_r[i]   <= 1'b0;
               sync_out[i] <= 1'b0;
            end
            else
            begin
               meta_r[i]   <= async_in[i];
               sync_out[i] <= meta_r[i];
            end
         end
      end
   endgenerate

   logic unused_rst_val;
   assign unused_rst_val = ^rst_val;

endmodule

`default_nettype wire

// ==== design/sssp_top.sv ====
/*
 * spi slave shift port: byte shifter stepped by the master's serial clock edges,
 * receive buffer, transmit load, completion flag, interrupt and wake request.
 * assumes the serial pins are asynchronous to clock and that the master's
 * clock high and low phases each last at least three clock periods.
 */
`timescale 1ns/1ps
`default_nettype none

`include "sssp_params.svh"

// How it works
// - bits move only on serial clock edges from the master; no clock generated.
// - completion flag sets when the eighth bit of a byte is latched.
// - software can read the present serial clock pin level.
// - shifting continues during core sleep, driven only by serial clock edges.
// - completed byte in sleep raises interrupt if enabled, and that interrupt wakes the core.
// - with select control on and select low, shift and drive data out.
// - with select control on, select high releases the data output two clocks later, even mid byte.
// - select high with select control on, or port disabled, forces the bit counter to zero.
// - with overwrite enabled, a new byte replaces an unread buffer byte.
module sssp_top (
   input  wire logic               clock,
   input  wire logic               rst_n,
   input  wire sssp_pkg::sssp_cfg_s cfg,
   input  wire logic               sclk_pin,
   input  wire logic               ss_n_pin,
   input  wire logic               sdi_pin,
   output logic                    sdo_o,
   output logic                    sdo_oe,
   input  wire logic               tx_wr_valid,
   input  wire sssp_pkg::sssp_byte_t tx_wr_data,
   output logic                    tx_wr_ready,
   input  wire logic               rx_rd,
   output sssp_pkg::sssp_byte_t    shift_buffer,
   input  wire logic               flag_clear,
   input  wire logic               err_clear,
   output sssp_pkg::sssp_flags_s   flags,
   output logic                    sclk_level,
   input  wire logic               int_enable,
   input  wire logic               core_sleep,
   output logic                    irq,
   output logic                    wake
);
   import sssp_pkg::*;

   // ************************************
   // reset release
   // ************************************
   logic [`SSSP_RST_STAGES-1:0] rst_pipe_r;
   logic                        rst_int_n;

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
         rst_pipe_r <= '0;
      else
         rst_pipe_r <= {rst_pipe_r[`SSSP_RST_STAGES-2:0], 1'b1};
   end

   assign rst_int_n = rst_pipe_r[`SSSP_RST_STAGES-1];

   // synchronisers reset to 0 whatever the pin idles at, so edges are ignored
   // until the sync chain and the edge delay both hold real pin levels
   logic [`SSSP_RST_STAGES-1:0] fill_r;

   always_ff @(posedge clock or negedge rst_int_n)
   begin
      if (!rst_int_n)
         fill_r <= '0;
      else
         fill_r <= {fill_r[`SSSP_RST_STAGES-2:0], 1'b1};
   end

   // ************************************
   // pin synchronisers and edge detect
   // ************************************
   logic [`SSSP_SYNC_W-1:0] pins_s;
   logic                    sclk_s;
   logic                    ss_n_s;
   logic                    sdi_s;
   logic                    sclk_d_r;
   logic                    sclk_d_nxt;

   sssp_sync #(
      .W (`SSSP_SYNC_W)
   ) u_sync (
      .clock    (clock),
      .rst_n    (rst_int_n),
      .async_in ({sclk_pin, ss_n_pin, sdi_pin}),
      .rst_val  ({`SSSP_SYNC_W{1'b0}}),
      .sync_out (pins_s)
   );

   assign sclk_s = pins_s[2];
   assign ss_n_s = pins_s[1];
   assign sdi_s  = pins_s[0];

   assign sclk_d_nxt = sclk_s;

   always_ff @(posedge clock or negedge rst_int_n)
   begin
      if (!rst_int_n)
         sclk_d_r <= 1'b0;
      else
         sclk_d_r <= sclk_d_nxt;
   end

   logic sclk_change;
   logic lead_edge;
   logic trail_edge;
   logic sample_edge;
   logic shift_edge;
   logic selected;

   // leading edge leaves the idle level, trailing edge returns to it
   assign sclk_change = sclk_s ^ sclk_d_r;
   assign lead_edge   = sclk_change & (sclk_d_r == cfg.clock_idle_polarity);
   assign trail_edge  = sclk_change & (sclk_s == cfg.clock_idle_polarity);
   // edge select high: out-data changes on trailing, input sampled on leading
   assign sample_edge = cfg.clock_edge_select ? lead_edge : trail_edge;
   assign shift_edge  = cfg.clock_edge_select ? trail_edge : lead_edge;

   // select is ignored when select control is off
   assign selected = cfg.port_enable_bit & (~cfg.ss_control_enable | ~ss_n_s);

   // ************************************
   // shifter, buffer and flags
   // ************************************
   sssp_state_e st_r;
   sssp_state_e st_nxt;
   sssp_cnt_t   cnt_r;
   sssp_cnt_t   cnt_nxt;
   sssp_byte_t  rx_sr_r;
   sssp_byte_t  rx_sr_nxt;
   sssp_byte_t  tx_sr_r;
   sssp_byte_t  tx_sr_nxt;
   sssp_byte_t  buf_r;
   sssp_byte_t  buf_nxt;
   logic        done_r;
   logic        done_nxt;
   logic        full_r;
   logic        full_nxt;
   logic        ovf_r;
   logic        ovf_nxt;
   logic        col_r;
   logic        col_nxt;
   logic        sclk_lvl_r;
   logic        sclk_lvl_nxt;

   // a load mid byte would corrupt the bit on the wire, so it is refused
   assign tx_wr_ready = (st_r != SSSP_XFER);

   always_comb
   begin
      sssp_byte_t rx_byte;
      rx_byte      = {rx_sr_r[`SSSP_BYTE_W-2:0], sdi_s};
      st_nxt       = st_r;
      cnt_nxt      = cnt_r;
      rx_sr_nxt    = rx_sr_r;
      tx_sr_nxt    = tx_sr_r;
      buf_nxt      = buf_r;
      done_nxt     = done_r;
      full_nxt     = full_r;
      ovf_nxt      = ovf_r;
      col_nxt      = col_r;
      sclk_lvl_nxt = sclk_s;

      // clears first, so a same-cycle set below wins
      if (rx_rd)
         full_nxt = 1'b0;
      if (flag_clear)
         done_nxt = 1'b0;
      if (err_clear)
      begin
         ovf_nxt = 1'b0;
         col_nxt = 1'b0;
      end

      if (tx_wr_valid)
      begin
         if (tx_wr_ready)
            tx_sr_nxt = tx_wr_data;
         else
            col_nxt = 1'b1;
      end

      case (st_r)
         SSSP_OFF:
         begin
            cnt_nxt = `SSSP_CNT_RST;
            if (cfg.port_enable_bit && fill_r[`SSSP_RST_STAGES-1])
               st_nxt = SSSP_IDLE;
         end
         SSSP_IDLE, SSSP_XFER:
         begin
            if (!cfg.port_enable_bit)
            begin
               st_nxt  = SSSP_OFF;
               cnt_nxt = `SSSP_CNT_RST;
            end
            else if (!selected)
            begin
               // partial byte is dropped; master realigns on next select
               st_nxt  = SSSP_IDLE;
               cnt_nxt = `SSSP_CNT_RST;
            end
            else
            begin
               // no dependence on core_sleep: shifting never stops for it
               if (shift_edge && (cnt_r != `SSSP_CNT_RST))
                  tx_sr_nxt = {tx_sr_r[`SSSP_BYTE_W-2:0], 1'b0};
               if (sample_edge)
               begin
                  rx_sr_nxt = rx_byte;
                  cnt_nxt   = cnt_r + 3'h1;
                  st_nxt    = SSSP_XFER;
                  if (cnt_r == `SSSP_LAST_BIT)
                  begin
                     st_nxt   = SSSP_IDLE;
                     done_nxt = 1'b1;
                     if (!full_nxt || cfg.buffer_overwrite_enable)
                     begin
                        buf_nxt  = rx_byte;
                        full_nxt = 1'b1;
                     end
                     else
                        ovf_nxt = 1'b1;
                  end
               end
            end
         end
         default:
         begin
            st_nxt  = SSSP_OFF;
            cnt_nxt = `SSSP_CNT_RST;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_int_n)
   begin
      if (!rst_int_n)
      begin
         st_r       <= SSSP_OFF;
         cnt_r      <= `SSSP_CNT_RST;
         rx_sr_r    <= `SSSP_BYTE_RST;
         tx_sr_r    <= `SSSP_BYTE_RST;
         buf_r      <= `SSSP_BYTE_RST;
         done_r     <= 1'b0;
         full_r     <= 1'b0;
         ovf_r      <= 1'b0;
         col_r      <= 1'b0;
         sclk_lvl_r <= 1'b0;
      end
      else
      begin
         st_r       <= st_nxt;
         cnt_r      <= cnt_nxt;
         rx_sr_r    <= rx_sr_nxt;
         tx_sr_r    <= tx_sr_nxt;
         buf_r      <= buf_nxt;
         done_r     <= done_nxt;
         full_r     <= full_nxt;
         ovf_r      <= ovf_nxt;
         col_r      <= col_nxt;
         sclk_lvl_r <= sclk_lvl_nxt;
      end
   end

   // ************************************
   // outputs
   // ************************************
   assign sdo_o  = tx_sr_r[`SSSP_BYTE_W-1];
   // released two clocks after the select pin rises, from synchronised copy
   assign sdo_oe = selected & (st_r != SSSP_OFF);

   assign shift_buffer             = buf_r;
   assign flags.transfer_done_flag = done_r;
   assign flags.buffer_full        = full_r;
   assign flags.overflow           = ovf_r;
   assign flags.write_collision    = col_r;
   assign sclk_level               = sclk_lvl_r;

   assign irq  = done_r & int_enable;
   assign wake = irq & core_sleep;

endmodule

`default_nettype wire

// ==== verification/sssp_master_model.sv ====
/* spi master model: drives serial clock, select and data in, samples data out.
   assumes a clock to pace bit halves; idle level and sampling edge per call. */
`timescale 1ns/1ps
`default_nettype none
module sssp_master_model (
   input  wire logic clock,
   input  wire logic sdo_o,
   input  wire logic sdo_oe,
   output var  logic sclk_pin,
   output var  logic ss_n_pin,
   output var  logic sdi_pin
);
   // *****
   // frames
   // *****
   initial
   begin
      sclk_pin = 1'b0;
      ss_n_pin = 1'b1;
      sdi_pin = 1'b0;
   end

   task automatic idle(input logic l);
      sclk_pin = l;
   endtask

   // n below 8 leaves a partial byte; h sets half period in clocks
   // p is the idle level; e high samples on the leading edge, low on the trailing
   task automatic xfer(input logic [7:0] d, input int n, input int h, input logic p, input logic e,
      output logic [7:0] q);
      q = 8'h00;
      ss_n_pin = 1'b0;
      repeat (h) @(negedge clock);
      for (int i = 7; i > 7 - n; i--)
      begin
         if (e)
            sdi_pin = d[i];
         repeat (h) @(negedge clock);
         sclk_pin = ~p;
         if (e)
            q[i] = sdo_oe ? sdo_o : 1'bx;
         else
            sdi_pin = d[i];
         repeat (h) @(negedge clock);
         sclk_pin = p;
         if (!e)
            q[i] = sdo_oe ? sdo_o : 1'bx;
      end
      repeat (h) @(negedge clock);
      ss_n_pin = 1'b1;
      // released line must not keep its last value
      sdi_pin = ~sdi_pin;
   endtask
endmodule
`default_nettype wire

// ==== verification/sssp_top_assertions.sv ====
/* port level checker for sssp_top.
   assumes bind onto sssp_top; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module sssp_top_assertions (
   input wire logic                  clock,
   input wire logic                  rst_n,
   input wire sssp_pkg::sssp_cfg_s   cfg,
   input wire logic                  sclk_pin,
   input wire logic                  ss_n_pin,
   input wire logic                  sdo_oe,
   input wire logic                  tx_wr_valid,
   input wire logic                  tx_wr_ready,
   input wire logic                  flag_clear,
   input wire sssp_pkg::sssp_flags_s flags,
   input wire logic                  sclk_level,
   input wire logic                  int_enable,
   input wire logic                  core_sleep,
   input wire logic                  irq,
   input wire logic                  wake
);
   import sssp_pkg::*;
   // *****
   // helpers
   // *****
   logic [3:0] quiet_r;
   logic [3:0] quiet_nxt;
   logic [2:0] up_r;
   logic [2:0] up_nxt;
   logic       last_r;
   // up_r hides the internal reset release and sync fill
   always_comb
   begin
      quiet_nxt = (sclk_pin != last_r) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
      up_nxt = up_r + {2'h0, up_r != 3'h7};
   end
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         quiet_r <= 4'h0;
         up_r <= 3'h0;
         last_r <= 1'b0;
      end
      else
      begin
         quiet_r <= quiet_nxt;
         up_r <= up_nxt;
         last_r <= sclk_pin;
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   oe_release_a: assert property ((up_r == 3'h7 && cfg.port_enable_bit && cfg.ss_control_enable && ss_n_pin) [*4]
      |-> !sdo_oe) else $error("data out still driven");
   oe_drive_a: assert property ((up_r == 3'h7 && cfg.port_enable_bit && cfg.ss_control_enable && !ss_n_pin) [*4]
      |-> sdo_oe) else $error("data out not driven");
   irq_flag_a: assert property (irq == (flags.transfer_done_flag && int_enable)) else $error("irq wrong");
   wake_sleep_a: assert property (wake == (irq && core_sleep)) else $error("wake wrong");
   flag_sclk_a: assert property ($rose(flags.transfer_done_flag) |-> quiet_r < 4'h8)
      else $error("flag without serial clock");
   tx_collide_a: assert property (tx_wr_valid && !tx_wr_ready |=> flags.write_collision)
      else $error("collision not flagged");
   flag_clear_a: assert property (flag_clear && quiet_r > 4'h7 |=> !flags.transfer_done_flag)
      else $error("flag not cleared");
   sclk_level_a: assert property ((up_r == 3'h7 && $stable(sclk_pin)) [*4] |-> sclk_level == sclk_pin)
      else $error("clock level wrong");
endmodule
bind sssp_top sssp_top_assertions i_chk (.clock, .rst_n, .cfg, .sclk_pin, .ss_n_pin, .sdo_oe, .tx_wr_valid,
   .tx_wr_ready, .flag_clear, .flags, .sclk_level, .int_enable, .core_sleep, .irq, .wake);
`default_nettype wire

// ==== verification/tb_spi_slave_shift_port.sv ====
/* self-checking bench for sssp_top with a master model.
   assumes the checker is bound by its own file. */
`timescale 1ns/1ps
`default_nettype none
module tb_spi_slave_shift_port;
   import sssp_pkg::*;
   logic clock = 1'b0, rst_n, tx_wr_valid, tx_wr_ready, rx_rd, flag_clear, err_clear;
   logic sclk_pin, ss_n_pin, sdi_pin, sdo_o, sdo_oe, sclk_level, int_enable, core_sleep, irq, wake;
   logic done_q = 1'b0;
   sssp_cfg_s cfg;
   sssp_flags_s flags;
   sssp_byte_t tx_wr_data, shift_buffer, a, q;
   sssp_byte_t exp_q[$];
   int miscompares = 0, tests_run = 0, cyc = 0;
   sssp_top i_sssp_top (.clock, .rst_n, .cfg, .sclk_pin, .ss_n_pin, .sdi_pin, .sdo_o, .sdo_oe, .tx_wr_valid,
      .tx_wr_data, .tx_wr_ready, .rx_rd, .shift_buffer, .flag_clear, .err_clear, .flags, .sclk_level,
      .int_enable, .core_sleep, .irq, .wake);
   sssp_master_model i_sssp_master_model (.clock, .sdo_o, .sdo_oe, .sclk_pin, .ss_n_pin, .sdi_pin);
   // *****
   // checking
   // *****
   always #5 clock = ~clock;
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1)
      begin
         miscompares++;
         $display("Error %0t: %s", $time, m);
      end
   endtask
   task automatic close_out;
      $display("tests_run %0d miscompares %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   always @(negedge clock)
   begin
      if (flags.transfer_done_flag === 1'b1 && done_q === 1'b0)
         chk(exp_q.size() > 0 && shift_buffer === exp_q.pop_front(), "rx byte");
      done_q = flags.transfer_done_flag;
   end
   always @(posedge clock)
   begin
      cyc++;
      if (cyc > 20000)
      begin
         miscompares++;
         close_out();
      end
   end
   // *****
   // stimulus
   // *****
   task automatic clr(input logic rd);
      rx_rd = rd;
      flag_clear = 1'b1;
      err_clear = 1'b1;
      @(negedge clock);
      rx_rd = 1'b0;
      flag_clear = 1'b0;
      err_clear = 1'b0;
      @(negedge clock);
   endtask
   task automatic byte_run(input sssp_byte_t t, input sssp_byte_t r, input logic rd);
      sssp_byte_t s;
      tx_wr_valid = 1'b1;
      tx_wr_data = t;
      @(negedge clock);
      tx_wr_valid = 1'b0;
      exp_q.push_back(r);
      i_sssp_master_model.xfer(r, 8, 5 + $urandom % 4, cfg.clock_idle_polarity, cfg.clock_edge_select, s);
      // four clocks let the clear land after the clock went quiet
      repeat (4) @(negedge clock);
      chk(s === t, "tx byte");
      chk(flags.buffer_full === 1'b1, "full");
      chk(irq === int_enable, "irq");
      chk(wake === (int_enable & core_sleep), "wake");
      clr(rd);
   endtask
   initial
   begin
      rst_n = 1'b0;
      cfg = 5'h1a;
      {tx_wr_valid, rx_rd, flag_clear, err_clear, int_enable, core_sleep} = 6'h00;
      tx_wr_data = 8'h00;
      void'($urandom(5));
      repeat (2) @(negedge clock);
      rst_n = 1'b1;
      repeat (4) @(negedge clock);
      for (int k = 0; k < 6; k++)
      begin
         {int_enable, core_sleep} = 2'(k);
         byte_run(8'($urandom), 8'($urandom), 1'b1);
      end
      $display("test stream done");
      fork
         i_sssp_master_model.xfer(8'h5a, 3, 6, cfg.clock_idle_polarity, cfg.clock_edge_select, q);
         begin
            repeat (20) @(negedge clock);
            tx_wr_valid = 1'b1;
            @(negedge clock);
            tx_wr_valid = 1'b0;
         end
      join
      repeat (4) @(negedge clock);
      chk(sdo_oe === 1'b0, "released");
      chk(flags.write_collision === 1'b1, "collision");
      clr(1'b1);
      byte_run(8'($urandom), 8'($urandom), 1'b1);
      $display("test abort done");
      a = 8'($urandom);
      byte_run(8'h00, a, 1'b0);
      exp_q.push_back(a);
      i_sssp_master_model.xfer(~a, 8, 6, cfg.clock_idle_polarity, cfg.clock_edge_select, q);
      repeat (4) @(negedge clock);
      chk(shift_buffer === a && flags.overflow === 1'b1, "kept");
      exp_q.delete();
      clr(1'b1);
      $display("test overflow done");
      cfg = 5'h0a;
      i_sssp_master_model.idle(1'b1);
      repeat (6) @(negedge clock);
      chk(sclk_level === 1'b1, "clock level");
      i_sssp_master_model.idle(1'b0);
      repeat (6) @(negedge clock);
      cfg = 5'h1b;
      repeat (4) @(negedge clock);
      byte_run(8'h00, a, 1'b0);
      byte_run(8'h00, ~a, 1'b1);
      $display("test overwrite done");
      // every idle level and sampling edge; select control off in the first two
      for (int m = 0; m < 4; m++)
      begin
         cfg = {1'b0, m[1], m[1] ^ m[0], m[0], 1'b1};
         i_sssp_master_model.idle(cfg.clock_idle_polarity);
         repeat (6) @(negedge clock);
         cfg.port_enable_bit = 1'b1;
         repeat (4) @(negedge clock);
         byte_run(8'($urandom), 8'($urandom), 1'b1);
      end
      $display("test modes done");
      close_out();
   end
endmodule
`default_nettype wire
